// [verif/pmr_manager.sv]
/* station manager model issuing register reads and writes.
   assumes the bench calls xfer; drives on the falling edge. */
`default_nettype none
module pmr_manager
    import pmr_pkg::*;
(
    input wire logic clk_sys,
    output var pmr_mgmt_req_t mgmt_req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial mgmt_req = '0;
    // one request cycle; released fields are scrambled
    task automatic xfer(input logic rd, input logic wr,
                        input logic [4:0] pa, input logic [4:0] idx,
                        input logic [15:0] wd);
        if (wr && idx == IDX_SPECIAL_MODES
            && wd[7:5] == PMR_M_RESERVED) return;
        if (wr && idx == IDX_SPECIAL_CTRL_STATUS && wd[14]
            && wd[13]) return;
        @(negedge clk_sys);
        mgmt_req <= {rd, wr, pa, idx, wd};
        @(negedge clk_sys);
        mgmt_req <= {2'b00, ~pa, ~idx, ~wd};
    endtask : xfer
endmodule : pmr_manager
`default_nettype wire

// [verif/pmr_regs_bench.sv]
/* self-checking bench for pmr_regs with a station manager model.
   assumes pmr_pkg, pmr_regs, pmr_manager and the monitor. */
`default_nettype none
module pmr_regs_bench
    import pmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys;
    logic rstn;
    logic soft_reset;
    pmr_mgmt_req_t mgmt_req;
    logic [15:0] mgmt_rdata;
    logic mgmt_rvalid;
    pmr_line_t line_in;
    logic [3:0] scs_low_nibble;
    pmr_ctrl_t ctrl;
    logic edpd_act;
    logic rx_blk;
    logic [15:0] exp_q[$];
    logic [31:0] seed;
    logic [15:0] wd;
    logic [3:0] nib;
    logic [18:0] xt [6];
    int err_total;
    int total_checks;
    pmr_manager pmr_manager_i (.clk_sys(clk_sys), .mgmt_req(mgmt_req));
    pmr_regs pmr_regs_i (.clk_sys(clk_sys), .rstn(rstn),
        .soft_reset(soft_reset), .mgmt_req(mgmt_req),
        .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
        .line_in(line_in), .scs_low_nibble(scs_low_nibble), .ctrl(ctrl),
        .energy_detect_powerdown_active(edpd_act),
        .rx_10m_blocked(rx_blk));
    always #25 clk_sys = ~clk_sys;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_step
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wait_n
    task automatic rd(input logic [4:0] pa, input logic [4:0] idx,
                      input logic [15:0] exp);
        exp_q.push_back(exp);
        pmr_manager_i.xfer(1'b1, 1'b0, pa, idx, 16'h0000);
    endtask : rd
    task automatic wr(input logic [4:0] pa, input logic [4:0] idx,
                      input logic [15:0] d);
        pmr_manager_i.xfer(1'b0, 1'b1, pa, idx, d);
        wait_n(3);
    endtask : wr
    // expected decode {an, speed, duplex, repeater, advertise, basic}
    task automatic ctrl_check(input logic [2:0] m);
        logic [11:0] e;
        case (m)
            3'h0: e = {4'b0000, ADV_NONE, BC_10HD};
            3'h1: e = {4'b0010, ADV_NONE, BC_10FD};
            3'h2: e = {4'b0100, ADV_NONE, BC_100HD};
            3'h3: e = {4'b0110, ADV_NONE, BC_100FD};
            3'h4: e = {4'b1100, ADV_100HD, BC_AN100};
            3'h5: e = {4'b1101, ADV_100HD, BC_AN100};
            default: e = {4'b1110, ADV_ALL, 4'hD};
        endcase
        check({4'h0, ctrl.an_enable, ctrl.speed_100, ctrl.full_duplex,
               ctrl.repeater, ctrl.advertise, ctrl.basic_ctrl},
              {4'h0, e});
        if (m >= 3'h2 && m <= 3'h5)
            check({15'h0, ctrl.crs_on_tx}, {15'h0, !m[0]});
    endtask : ctrl_check
    task automatic conclude();
        check(16'(exp_q.size()), 16'h0000);
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    // read answers against the oldest note
    always @(negedge clk_sys) begin
        if (mgmt_rvalid === 1'b1) begin
            if (exp_q.size() == 0)
                check({15'h0, mgmt_rvalid}, 16'h0000);
            else
                check(mgmt_rdata, exp_q.pop_front());
        end
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        conclude();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        rstn = 1'b0;
        soft_reset = 1'b0;
        line_in = '0;
        line_in.crossover_strap_enable = 1'b1;
        line_in.negotiated_100 = 1'b1;
        line_in.negotiated_fd = 1'b1;
        seed = 32'h7D896500;
        nib = seed[11:8];
        scs_low_nibble = nib;
        // strap, written word, expected {auto, swap}
        xt = '{19'h4003E, 19'h4803E, 19'h0003C, 19'h60000, 19'h68001,
               19'h71002};
        wait_n(10);
        rstn = 1'b1;
        wait_n(4);
        rd(ADDR_RESET, IDX_AN_EXPANSION, 16'h0000);
        rd(ADDR_RESET, IDX_MODE_CTRL_STATUS, 16'h0002);
        rd(ADDR_RESET, IDX_SPECIAL_MODES, 16'h00E1);
        rd(ADDR_RESET, 5'h05, 16'h0000);
        ctrl_check(3'h7);
        // latched flags: pulse, then hold page received
        line_in[8:5] = 4'hF;
        wait_n(4);
        line_in[8:7] = 2'b00;
        wait_n(4);
        rd(ADDR_RESET, IDX_AN_EXPANSION, 16'h001B);
        rd(ADDR_RESET, IDX_AN_EXPANSION, 16'h0009);
        line_in.page_received = 1'b1;
        wait_n(4);
        rd(ADDR_RESET, IDX_AN_EXPANSION, 16'h000B);
        rd(ADDR_RESET, IDX_AN_EXPANSION, 16'h000B);
        line_in.page_received = 1'b0;
        // every mode code, reserved one refused by the manager
        for (int m = 0; m < 8; m++) begin
            seed = lfsr_step(seed);
            wr(ADDR_RESET, IDX_SPECIAL_MODES,
               {seed[15:8], m[2:0], ADDR_RESET});
            if (m != 6) begin
                rd(ADDR_RESET, IDX_SPECIAL_MODES,
                   {8'h00, m[2:0], ADDR_RESET});
                ctrl_check(m[2:0]);
            end
        end
        // move the address, old one goes silent
        wr(ADDR_RESET, IDX_SPECIAL_MODES, 16'h00EA);
        pmr_manager_i.xfer(1'b1, 1'b0, ADDR_RESET, IDX_SPECIAL_MODES,
                           16'h0000);
        rd(5'h0A, IDX_SPECIAL_MODES, 16'h00EA);
        // power-down enable with scrambled reserved bits
        wr(5'h0A, IDX_MODE_CTRL_STATUS, seed[15:0] | 16'h2000);
        rd(5'h0A, IDX_MODE_CTRL_STATUS, 16'h2002);
        check({15'h0, ctrl.edpd_enable}, 16'h0001);
        check({15'h0, edpd_act}, 16'h0000);
        // crossover, pll lock and read-only nibble
        for (int i = 0; i < 6; i++) begin
            line_in.crossover_strap_enable = xt[i][18];
            line_in.polarity_reversed = i[0];
            seed = lfsr_step(seed);
            nib = seed[3:0];
            scs_low_nibble = nib;
            wait_n(4);
            wd = xt[i][17:2];
            wr(5'h0A, IDX_SPECIAL_CTRL_STATUS, wd);
            rd(5'h0A, IDX_SPECIAL_CTRL_STATUS,
               (wd & 16'hE400) | {11'h0, i[0], nib});
            check({14'h0, ctrl.auto_crossover, ctrl.crossover_swap},
                  {14'h0, xt[i][1:0]});
            check({14'h0, rx_blk, ctrl.rx_pll_reference_lock},
                  {14'h0, {2{wd[10]}}});
        end
        wr(5'h0A, IDX_SPECIAL_CTRL_STATUS, 16'hE000);
        rd(5'h0A, IDX_SPECIAL_CTRL_STATUS, {11'h620, 1'b1, nib});
        // soft reset keeps persisting fields
        soft_reset = 1'b1;
        wait_n(1);
        soft_reset = 1'b0;
        wait_n(3);
        rd(5'h0A, IDX_SPECIAL_MODES, 16'h00EA);
        rd(5'h0A, IDX_MODE_CTRL_STATUS, 16'h0002);
        rd(5'h0A, IDX_SPECIAL_CTRL_STATUS, {11'h020, 1'b1, nib});
        wait_n(4);
        conclude();
    end
endmodule : pmr_regs_bench
bind pmr_regs pmr_regs_monitor pmr_regs_monitor_i (.clk_sys(clk_sys),
    .rstn(rstn), .soft_reset(soft_reset), .mgmt_req(mgmt_req),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
    .line_in(line_in), .scs_low_nibble(scs_low_nibble), .ctrl(ctrl),
    .energy_detect_powerdown_active(energy_detect_powerdown_active),
    .rx_10m_blocked(rx_10m_blocked));
`default_nettype wire

// [verif/pmr_regs_monitor.sv]
/* port checker for the phy mode register bank.
   assumes it is bound into pmr_regs, one clk_sys domain. */
`default_nettype none
module pmr_regs_monitor
    import pmr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic soft_reset,
    input wire pmr_mgmt_req_t mgmt_req,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_rvalid,
    input wire pmr_line_t line_in,
    input wire logic [3:0] scs_low_nibble,
    input wire pmr_ctrl_t ctrl,
    input wire logic energy_detect_powerdown_active,
    input wire logic rx_10m_blocked
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] addr_sh_ff;
    logic [2:0] mode_sh_ff;
    logic hit;
    default clocking mon_cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------
    // shadow of address and mode, kept across soft reset
    // ------------------------------------------------------------
    assign hit = (mgmt_req.rd | mgmt_req.wr)
        && mgmt_req.phy_addr == addr_sh_ff;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            addr_sh_ff <= ADDR_RESET;
            mode_sh_ff <= MODE_RESET;
        end else if (hit && mgmt_req.wr
                     && mgmt_req.reg_idx == IDX_SPECIAL_MODES) begin
            addr_sh_ff <= mgmt_req.wdata[4:0];
            mode_sh_ff <= mgmt_req.wdata[7:5];
        end
    end
    read_answer_a: assert property (
        mgmt_req.rd && hit |=> mgmt_rvalid) else $error("no read answer");
    foreign_addr_a: assert property (
        !(mgmt_req.rd && hit) |=> !mgmt_rvalid)
        else $error("answer without matching read");
    idle_rdata_a: assert property (
        !mgmt_rvalid |-> mgmt_rdata == 16'h0000) else $error("idle data");
    own_np_zero_a: assert property (
        mgmt_rvalid && $past(mgmt_req.reg_idx) == IDX_AN_EXPANSION
        |-> mgmt_rdata[15:5] == 11'h000 && !mgmt_rdata[EXP_NP_BIT])
        else $error("expansion reserved or next page bit set");
    addr_readback_a: assert property (
        mgmt_rvalid && $past(mgmt_req.reg_idx) == IDX_SPECIAL_MODES
        |-> mgmt_rdata[7:0] == {$past(mode_sh_ff), $past(addr_sh_ff)})
        else $error("mode or address readback wrong");
    pll_lock_a: assert property (
        hit && mgmt_req.wr && mgmt_req.reg_idx == IDX_SPECIAL_CTRL_STATUS
        |-> ##2 rx_10m_blocked == $past(mgmt_req.wdata[SCS_PLL_BIT], 2))
        else $error("pll lock output wrong");
    powerdown_off_a: assert property (
        soft_reset |-> ##2 !ctrl.edpd_enable
        && !energy_detect_powerdown_active) else $error("powerdown kept");
    forced_10m_a: assert property (
        (mode_sh_ff[2:1] == 2'b00 && $stable(mode_sh_ff)) [*3]
        |-> !ctrl.an_enable && !ctrl.speed_100
        && ctrl.full_duplex == mode_sh_ff[0]) else $error("10M decode");
    forced_100m_a: assert property (
        (mode_sh_ff[2:1] == 2'b01 && $stable(mode_sh_ff)) [*3]
        |-> !ctrl.an_enable && ctrl.speed_100
        && ctrl.crs_on_tx == !mode_sh_ff[0]) else $error("100M decode");
    an100_mode_a: assert property (
        (mode_sh_ff == PMR_M_AN100HD) [*3] |-> ctrl.an_enable
        && ctrl.advertise == ADV_100HD && ctrl.basic_ctrl == BC_AN100
        && ctrl.crs_on_tx) else $error("negotiated 100M decode");
    repeater_mode_a: assert property (
        (mode_sh_ff == PMR_M_REPEATER) [*3] |-> ctrl.repeater
        && ctrl.an_enable && ctrl.advertise == ADV_100HD
        && !ctrl.crs_on_tx) else $error("repeater decode");
    all_mode_a: assert property (
        (mode_sh_ff == PMR_M_ALL) [*3] |-> ctrl.an_enable
        && ctrl.advertise == ADV_ALL) else $error("all capable decode");
    swap_manual_a: assert property (
        ctrl.crossover_swap |-> !ctrl.auto_crossover)
        else $error("swap while automatic");
endmodule : pmr_regs_monitor
`default_nettype wire

// [verilog/pmr_pkg.sv]
/*
 * package for the phy mode, crossover and status register bank:
 * register indices, field positions, reset values, mode codes, timing.
 * assumes a 20 MHz system clock and 5-bit management register indices.
 */
`default_nettype none
package pmr_pkg;
    // ------------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------------
    localparam logic [4:0] IDX_AN_EXPANSION = 5'h06;
    localparam logic [4:0] IDX_MODE_CTRL_STATUS = 5'h11;
    localparam logic [4:0] IDX_SPECIAL_MODES = 5'h12;
    localparam logic [4:0] IDX_SPECIAL_CTRL_STATUS = 5'h1B;
    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int EXP_PDF_BIT = 4;
    localparam int EXP_LP_NP_BIT = 3;
    localparam int EXP_NP_BIT = 2;
    localparam int EXP_PAGE_BIT = 1;
    localparam int EXP_LP_AN_BIT = 0;
    localparam int MCS_EDPD_BIT = 13;
    localparam int MCS_ENERGY_BIT = 1;
    localparam int SM_MODE_LSB = 5;
    localparam int SM_ADDR_LSB = 0;
    localparam int SCS_OVR_BIT = 15;
    localparam int SCS_AUTO_BIT = 14;
    localparam int SCS_STATE_BIT = 13;
    localparam int SCS_PLL_BIT = 10;
    localparam int SCS_POL_BIT = 4;
    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] MODE_RESET = 3'h7;
    localparam logic [4:0] ADDR_RESET = 5'h01;
    // ------------------------------------------------------------------
    // operating modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PMR_M_10HD = 3'b000,
        PMR_M_10FD = 3'b001,
        PMR_M_100HD = 3'b010,
        PMR_M_100FD = 3'b011,
        PMR_M_AN100HD = 3'b100,
        PMR_M_REPEATER = 3'b101,
        PMR_M_RESERVED = 3'b110,
        PMR_M_ALL = 3'b111
    } pmr_mode_t;
    // register-0 defaults as {speed, an enable, restart-free, duplex}
    localparam logic [3:0] BC_10HD = 4'h0;
    localparam logic [3:0] BC_10FD = 4'h1;
    localparam logic [3:0] BC_100HD = 4'h8;
    localparam logic [3:0] BC_100FD = 4'h9;
    localparam logic [3:0] BC_AN100 = 4'hC;
    localparam logic [3:0] BC_ALL = 4'h4;
    localparam logic [3:0] ADV_100HD = 4'h4;
    localparam logic [3:0] ADV_ALL = 4'hF;
    localparam logic [3:0] ADV_NONE = 4'h0;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int ENERGY_TIMEOUT_MS = 256;
    localparam longint ENERGY_TIMEOUT_CYC =
        (64'(ENERGY_TIMEOUT_MS) * 64'(CLK_HZ)) / 64'd1000;
    localparam int ENERGY_CNT_W = 23;
    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] phy_addr;
        logic [4:0] reg_idx;
        logic [15:0] wdata;
    } pmr_mgmt_req_t;
    typedef struct packed {
        logic parallel_fault;
        logic page_received;
        logic lp_next_page;
        logic lp_an_able;
        logic energy_valid;
        logic polarity_reversed;
        logic crossover_strap_enable;
        logic negotiated_100;
        logic negotiated_fd;
    } pmr_line_t;
    typedef struct packed {
        logic an_enable;
        logic speed_100;
        logic full_duplex;
        logic crs_on_tx;
        logic repeater;
        logic [3:0] advertise;
        logic [3:0] basic_ctrl;
        logic edpd_enable;
        logic auto_crossover;
        logic crossover_swap;
        logic rx_pll_reference_lock;
    } pmr_ctrl_t;
endpackage : pmr_pkg
`default_nettype wire

// [verilog/pmr_regs.sv]
/*
 * management-visible phy mode, crossover and status registers.
 * assumes an external serial management engine presents one-cycle
 * read/write strobes with address and data in the clk_sys domain,
 * and a line-side block supplies status levels from another domain.
 */
`default_nettype none
// Overview of operation
// - latch parallel detection fault at expansion bit 4
// - latch page received at expansion bit 1
// - own next page zero, partner at bit 3
// - partner negotiation ability at bit 0
// - power-down only while control bit 13 set
// - clear energy present after 256ms quiet
// - energy present one on hardware reset
// - answer at five-bit address, default 00001
// - mode from bits 7:5, default 111
// - modes 000/001 forced 10M half/full
// - modes 010/011 forced 100M, crs choice
// - mode 100 negotiates 100M half only
// - mode 101 repeater, crs on receive
// - mode 111 advertise all, follow result
// - override zero lets strap pin rule crossover
// - bit 14 enables auto crossover under override
// - bit 13 swaps pairs in manual crossover
// - bit 10 locks 10M pll to reference
// - bit 4 shows reversed receive polarity
// - low nibble read-only, writes ignored
module pmr_regs
    import pmr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic soft_reset,
    input wire pmr_mgmt_req_t mgmt_req,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_rvalid,
    input wire pmr_line_t line_in,
    input wire logic [3:0] scs_low_nibble,
    output pmr_ctrl_t ctrl,
    output logic energy_detect_powerdown_active,
    output logic rx_10m_blocked
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic parallel_fault;
        logic page_received;
        logic energy_present;
        logic [ENERGY_CNT_W-1:0] quiet_cnt;
        logic edpd_enable;
        logic [2:0] mode;
        logic [4:0] management_address;
        logic ovr;
        logic auto_en;
        logic xstate;
        logic rx_pll_reference_lock;
        logic [15:0] rdata;
        logic rvalid;
        pmr_ctrl_t ctrl;
        logic edpd_active;
        logic rx_blocked;
    } pmr_state_t;

    localparam logic [ENERGY_CNT_W-1:0] QUIET_MAX =
        ENERGY_CNT_W'(ENERGY_TIMEOUT_CYC - 1);

    pmr_state_t st_ff;
    pmr_state_t nxt_st;
    pmr_line_t line_s;
    logic [3:0] nib_s;
    logic hit;
    logic rd_hit;
    logic wr_hit;

    // ------------------------------------------------------------------
    // line-side synchronisers
    // ------------------------------------------------------------------
    pmr_sync #(.W($bits(pmr_line_t))) u_sync_line (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .d(line_in),
        .q(line_s)
    );
    pmr_sync #(.W(4)) u_sync_nib (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .d(scs_low_nibble),
        .q(nib_s)
    );

    // register read mux
    function automatic logic [15:0] read_word(input pmr_state_t s,
                                              input pmr_line_t l,
                                              input logic [4:0] idx,
                                              input logic [3:0] nib);
        logic [15:0] w;
        w = 16'h0000;
        case (idx)
            IDX_AN_EXPANSION: begin
                w[EXP_PDF_BIT] = s.parallel_fault;
                w[EXP_LP_NP_BIT] = l.lp_next_page;
                w[EXP_NP_BIT] = 1'b0;
                w[EXP_PAGE_BIT] = s.page_received;
                w[EXP_LP_AN_BIT] = l.lp_an_able;
            end
            IDX_MODE_CTRL_STATUS: begin
                w[MCS_EDPD_BIT] = s.edpd_enable;
                w[MCS_ENERGY_BIT] = s.energy_present;
            end
            IDX_SPECIAL_MODES: begin
                w[SM_MODE_LSB +: 3] = s.mode;
                w[SM_ADDR_LSB +: 5] = s.management_address;
            end
            IDX_SPECIAL_CTRL_STATUS: begin
                w[SCS_OVR_BIT] = s.ovr;
                w[SCS_AUTO_BIT] = s.auto_en;
                w[SCS_STATE_BIT] = s.xstate;
                w[SCS_PLL_BIT] = s.rx_pll_reference_lock;
                w[SCS_POL_BIT] = l.polarity_reversed;
                w[3:0] = nib; // undefined value, line-side
            end
            default: w = 16'h0000;
        endcase
        return w;
    endfunction : read_word

    // mode decode into link controls
    function automatic pmr_ctrl_t decode_mode(input logic [2:0] m,
                                              input pmr_line_t l);
        pmr_ctrl_t c;
        c = '0;
        case (m)
            PMR_M_10HD: begin
                c.basic_ctrl = BC_10HD;
                c.crs_on_tx = 1'b1;
            end
            PMR_M_10FD: begin
                c.basic_ctrl = BC_10FD;
                c.full_duplex = 1'b1;
            end
            PMR_M_100HD: begin
                c.basic_ctrl = BC_100HD;
                c.speed_100 = 1'b1;
                c.crs_on_tx = 1'b1;
            end
            PMR_M_100FD: begin
                c.basic_ctrl = BC_100FD;
                c.speed_100 = 1'b1;
                c.full_duplex = 1'b1;
            end
            PMR_M_AN100HD: begin
                c.basic_ctrl = BC_AN100;
                c.advertise = ADV_100HD;
                c.an_enable = 1'b1;
                c.speed_100 = 1'b1;
                c.crs_on_tx = 1'b1;
            end
            PMR_M_REPEATER: begin
                c.basic_ctrl = BC_AN100;
                c.advertise = ADV_100HD;
                c.an_enable = 1'b1;
                c.speed_100 = 1'b1;
                c.repeater = 1'b1;
            end
            PMR_M_ALL: begin
                c.advertise = ADV_ALL;
                c.an_enable = 1'b1;
                c.speed_100 = l.negotiated_100;
                c.full_duplex = l.negotiated_fd;
                c.crs_on_tx = ~l.negotiated_fd;
                c.basic_ctrl = {l.negotiated_100, BC_ALL[2:1],
                                l.negotiated_fd};
            end
            default: begin
                // reserved code, left inert
                c.advertise = ADV_NONE;
            end
        endcase
        return c;
    endfunction : decode_mode

    // address and strobe decode
    assign hit = (mgmt_req.phy_addr == st_ff.management_address);
    assign rd_hit = mgmt_req.rd & hit;
    assign wr_hit = mgmt_req.wr & hit;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rvalid = rd_hit;
        nxt_st.rdata = rd_hit ?
            read_word(st_ff, line_s, mgmt_req.reg_idx, nib_s) : 16'h0000;
        // latched-high flags, clear on read, set wins
        if (rd_hit && mgmt_req.reg_idx == IDX_AN_EXPANSION) begin
            nxt_st.parallel_fault = 1'b0;
            nxt_st.page_received = 1'b0;
        end
        if (line_s.parallel_fault) begin
            nxt_st.parallel_fault = 1'b1;
        end
        if (line_s.page_received) begin
            nxt_st.page_received = 1'b1;
        end
        // energy watchdog
        if (line_s.energy_valid) begin
            nxt_st.quiet_cnt = '0;
            nxt_st.energy_present = 1'b1;
        end else if (st_ff.quiet_cnt == QUIET_MAX) begin
            nxt_st.energy_present = 1'b0;
        end else begin
            nxt_st.quiet_cnt = st_ff.quiet_cnt + 1'b1;
        end
        // register writes
        if (wr_hit) begin
            case (mgmt_req.reg_idx)
                IDX_MODE_CTRL_STATUS: begin
                    nxt_st.edpd_enable = mgmt_req.wdata[MCS_EDPD_BIT];
                end
                IDX_SPECIAL_MODES: begin
                    nxt_st.mode = mgmt_req.wdata[SM_MODE_LSB +: 3];
                    nxt_st.management_address =
                        mgmt_req.wdata[SM_ADDR_LSB +: 5];
                end
                IDX_SPECIAL_CTRL_STATUS: begin
                    nxt_st.ovr = mgmt_req.wdata[SCS_OVR_BIT];
                    nxt_st.auto_en = mgmt_req.wdata[SCS_AUTO_BIT];
                    nxt_st.xstate = mgmt_req.wdata[SCS_STATE_BIT];
                    nxt_st.rx_pll_reference_lock =
                        mgmt_req.wdata[SCS_PLL_BIT];
                end
                default: begin
                    nxt_st.rx_blocked = st_ff.rx_blocked;
                end
            endcase
        end
        // soft reset: defaults except persisting fields, latched flags and energy flag
        if (soft_reset) begin
            nxt_st.edpd_enable = 1'b0;
            nxt_st.ovr = 1'b0;
            nxt_st.auto_en = 1'b0;
            nxt_st.xstate = 1'b0; // mode, address, pll kept
        end
        // derived link controls
        nxt_st.ctrl = decode_mode(st_ff.mode, line_s);
        nxt_st.ctrl.edpd_enable = st_ff.edpd_enable;
        if (st_ff.ovr) begin
            nxt_st.ctrl.auto_crossover = st_ff.auto_en;
            nxt_st.ctrl.crossover_swap =
                ~st_ff.auto_en & st_ff.xstate;
        end else begin
            nxt_st.ctrl.auto_crossover =
                line_s.crossover_strap_enable;
            nxt_st.ctrl.crossover_swap = 1'b0;
        end
        nxt_st.ctrl.rx_pll_reference_lock = st_ff.rx_pll_reference_lock;
        nxt_st.rx_blocked = st_ff.rx_pll_reference_lock;
        nxt_st.edpd_active =
            st_ff.edpd_enable & ~st_ff.energy_present;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
            st_ff.energy_present <= 1'b1;
            st_ff.mode <= MODE_RESET;
            st_ff.management_address <= ADDR_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register
    assign mgmt_rdata = st_ff.rdata;
    assign mgmt_rvalid = st_ff.rvalid;
    assign ctrl = st_ff.ctrl;
    assign energy_detect_powerdown_active = st_ff.edpd_active;
    assign rx_10m_blocked = st_ff.rx_blocked;
endmodule : pmr_regs
`default_nettype wire

// [verilog/pmr_sync.sv]
/*
 * two flip-flop synchroniser for a bundle of level inputs.
 * assumes inputs are slow levels from the line side or pins.
 */
`default_nettype none
module pmr_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    // first stage feeds only the second
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= '0;
            q_ff <= '0;
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end
    assign q = q_ff;
endmodule : pmr_sync
`default_nettype wire
